/* File: design/ifd_decoder.sv */
// Instruction format decoder: splits each fetched word into opcode and operand fields.
// Assumes program memory presents a word with a valid strobe on clk.
// What this block does
// - Take each instruction as one 12-bit word of opcode and operands.
// - Destination bit zero sends the result to the accumulator.
// - Destination bit one writes the result back to the addressed register.
// - Register address spans 0x00 to 0x1F, one of 32 bank registers.
// - Byte format: opcode 11..6, destination bit 5, register 4..0.
// - Bit format: opcode 11..8, bit number 7..5, register 4..0.
// - Bit number selects one bit of the addressed 8-bit register.
// - Literal format: opcode 11..8 and an 8-bit constant 7..0.
// - Jump format: opcode 11..9 and a 9-bit target 8..0.
// - One instruction cycle, two when a skip is taken or PC changes.
// - Each instruction cycle is four oscillator periods.
// - Don't-care encoding bits never change the decode.
`default_nettype none
module ifd_decoder (
    input  wire logic                    clk,           // Core oscillator.
    input  wire logic                    rstn,          // Synchronous reset, active low.
    input  wire logic                    instr_valid,   // Fetched word is present.
    input  wire logic [11:0]             instr_word,    // Fetched instruction word.
    input  wire logic                    skip_true,     // Datapath reports a true test.
    output var  ifd_pkg::ifd_fmt_t       fmt_reg,       // Decoded format.
    output var  logic [5:0]              opcode_reg,    // Opcode, left aligned to 6 bits.
    output var  logic                    dest_acc_reg,  // Result goes to accumulator.
    output var  logic                    dest_file_reg, // Result goes to register file.
    output var  logic [4:0]              file_addr_reg, // Register address.
    output var  logic [2:0]              bit_num_reg,   // Bit number.
    output var  logic [7:0]              bit_mask_reg,  // One-hot bit select.
    output var  logic [7:0]              literal_reg,   // 8-bit constant.
    output var  logic [8:0]              jump_target_reg, // Jump target.
    output var  logic                    two_cycle_reg, // Instruction takes two cycles.
    output var  logic                    is_cond_reg,   // Instruction is a conditional skip.
    output var  logic [1:0]              phase_out_reg, // Period within the cycle.
    output var  logic                    cycle_end_reg  // Final period of the cycle.
);
    import ifd_pkg::*;

    logic [1:0]  phase_w;
    logic        last_w;
    logic        busy_reg;
    ifd_fmt_t    fmt_next;
    logic        cond_next;
    logic        pcchg_next;

    // Period counter for the instruction cycle.
    ifd_phase u_phase (
        .clk       (clk),
        .rstn      (rstn),
        .phase_reg (phase_w),
        .last_reg  (last_w)
    );

    // Format chosen from the top bits; low bits outside a field are ignored.
    always_comb begin
        fmt_next   = IFD_FMT_LIT;
        cond_next  = 1'b0;
        pcchg_next = 1'b0;
        if (instr_word[11:OPJ_LSB] == OPJ_JUMP) begin
            fmt_next   = IFD_FMT_JUMP;
            pcchg_next = 1'b1;
        end else if (instr_word[11:OPN_LSB] >= GRP_BITLO && instr_word[11:OPN_LSB] <= GRP_BITHI) begin
            fmt_next  = IFD_FMT_BIT;
            cond_next = (instr_word[11:OPN_LSB] >= OPN_BITSKIP);
        end else if (instr_word[11:OPN_LSB] < GRP_BITLO && instr_word[11:OPB_LSB] != 6'h00) begin
            fmt_next  = IFD_FMT_BYTE;
            cond_next = (instr_word[11:OPB_LSB] == OPB_DECSKIP) || (instr_word[11:OPB_LSB] == OPB_INCSKIP);
        end else if (instr_word[11:OPN_LSB] == GRP_MISC) begin
            fmt_next = IFD_FMT_LIT;
        end else begin
            fmt_next   = IFD_FMT_LIT;
            pcchg_next = (instr_word[11:OPN_LSB] == GRP_RETURN) || (instr_word[11:OPN_LSB] == GRP_CALL);
        end
    end

    // Field outputs load at a cycle boundary unless a second cycle is owed; a refused word leaves no trace.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            fmt_reg         <= IFD_FMT_LIT;
            opcode_reg      <= 6'h00;
            dest_acc_reg    <= 1'b0;
            dest_file_reg   <= 1'b0;
            file_addr_reg   <= 5'h00;
            bit_num_reg     <= 3'h0;
            bit_mask_reg    <= 8'h00;
            literal_reg     <= 8'h00;
            jump_target_reg <= 9'h000;
            is_cond_reg     <= 1'b0;
        end else if (last_w && instr_valid && !busy_reg) begin
            fmt_reg         <= fmt_next;
            is_cond_reg     <= cond_next;
            file_addr_reg   <= instr_word[FILE_W-1:0];
            bit_num_reg     <= instr_word[BIT_LSB+BIT_W-1:BIT_LSB];
            bit_mask_reg    <= 8'h01 << instr_word[BIT_LSB+BIT_W-1:BIT_LSB];
            literal_reg     <= instr_word[LIT_W-1:0];
            jump_target_reg <= instr_word[JMP_W-1:0];
            dest_acc_reg    <= (fmt_next == IFD_FMT_BYTE) && !instr_word[DEST_POS];
            dest_file_reg   <= (fmt_next == IFD_FMT_BYTE) && instr_word[DEST_POS];
            case (fmt_next)
                IFD_FMT_BYTE: opcode_reg <= instr_word[11:OPB_LSB];
                IFD_FMT_BIT:  opcode_reg <= {instr_word[11:OPN_LSB], 2'b00};
                IFD_FMT_JUMP: opcode_reg <= {instr_word[11:OPJ_LSB], 3'b000};
                default:      opcode_reg <= {instr_word[11:OPN_LSB], 2'b00};
            endcase
        end
    end

    // Second cycle owed after a taken skip or a program counter change.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            busy_reg      <= 1'b0;
            two_cycle_reg <= 1'b0;
        end else if (last_w) begin
            if (busy_reg) begin
                busy_reg      <= 1'b0;
                two_cycle_reg <= 1'b0;
            end else if (instr_valid) begin
                busy_reg      <= pcchg_next || (cond_next && skip_true);
                two_cycle_reg <= pcchg_next || (cond_next && skip_true);
            end
        end
    end

    // Phase outputs re-registered so every output comes from a flip-flop.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            phase_out_reg <= 2'h0;
            cycle_end_reg <= 1'b0;
        end else begin
            phase_out_reg <= phase_w;
            cycle_end_reg <= last_w;
        end
    end

    // A byte word with the destination bit clear steers the result to the accumulator.
    property p_dest_acc;
        @(posedge clk) disable iff (!rstn)
        (last_w && instr_valid && !busy_reg && fmt_next == IFD_FMT_BYTE && !instr_word[DEST_POS])
            |=> dest_acc_reg && !dest_file_reg;
    endproperty
    a_dest_acc: assert property (p_dest_acc) else $error("dest zero not to accumulator");

    // A byte word with the destination bit set steers the result back to the register.
    property p_dest_file;
        @(posedge clk) disable iff (!rstn)
        (last_w && instr_valid && !busy_reg && fmt_next == IFD_FMT_BYTE && instr_word[DEST_POS])
            |=> dest_file_reg && !dest_acc_reg;
    endproperty
    a_dest_file: assert property (p_dest_file) else $error("dest one not to file");

    // The register address is the low five bits of every accepted word.
    property p_file_addr;
        @(posedge clk) disable iff (!rstn)
        (last_w && instr_valid && !busy_reg) |=> file_addr_reg == $past(instr_word[4:0]);
    endproperty
    a_file_addr: assert property (p_file_addr) else $error("register address wrong");

    // Byte words keep their full six-bit opcode.
    property p_byte_op;
        @(posedge clk) disable iff (!rstn)
        (last_w && instr_valid && !busy_reg && fmt_next == IFD_FMT_BYTE) |=> opcode_reg == $past(instr_word[11:6]);
    endproperty
    a_byte_op: assert property (p_byte_op) else $error("byte opcode wrong");

    // The one-hot mask follows the bit number field.
    property p_bit_mask;
        @(posedge clk) disable iff (!rstn)
        (last_w && instr_valid && !busy_reg) |=> bit_mask_reg == (8'h01 << $past(instr_word[7:5]));
    endproperty
    a_bit_mask: assert property (p_bit_mask) else $error("bit select wrong");

    // The constant is the low byte of every accepted word.
    property p_literal;
        @(posedge clk) disable iff (!rstn)
        (last_w && instr_valid && !busy_reg) |=> literal_reg == $past(instr_word[7:0]);
    endproperty
    a_literal: assert property (p_literal) else $error("literal wrong");

    // A jump word yields the jump format and its nine-bit target.
    property p_jump;
        @(posedge clk) disable iff (!rstn)
        (last_w && instr_valid && !busy_reg && instr_word[11:9] == OPJ_JUMP)
            |=> fmt_reg == IFD_FMT_JUMP && jump_target_reg == $past(instr_word[8:0]);
    endproperty
    a_jump: assert property (p_jump) else $error("jump decode wrong");

    // A taken skip or a program counter change owes exactly one more cycle.
    sequence s_taken;
        last_w && instr_valid && !busy_reg && (pcchg_next || (cond_next && skip_true));
    endsequence
    property p_two_cycle;
        @(posedge clk) disable iff (!rstn)
        s_taken |=> busy_reg [*4] ##1 !busy_reg;
    endproperty
    a_two_cycle: assert property (p_two_cycle) else $error("second cycle not four periods");

    // Bit words carry the bit number and the four-bit opcode group.
    property p_bit_fields;
        @(posedge clk) disable iff (!rstn)
        (last_w && instr_valid && !busy_reg && fmt_next == IFD_FMT_BIT)
            |=> bit_num_reg == $past(instr_word[7:5]) && opcode_reg == {$past(instr_word[11:8]), 2'b00};
    endproperty
    a_bit_fields: assert property (p_bit_fields) else $error("bit format fields wrong");

    // Operand bits never leak into the unused low end of a short opcode.
    property p_opcode_pad;
        @(posedge clk) disable iff (!rstn)
        (last_w && instr_valid && !busy_reg && fmt_next != IFD_FMT_BYTE) |=> opcode_reg[1:0] == 2'b00;
    endproperty
    a_opcode_pad: assert property (p_opcode_pad) else $error("operand bits leak into opcode");

    // The cycle boundary output repeats every four oscillator periods.
    property p_cycle_end;
        @(posedge clk) disable iff (!rstn)
        cycle_end_reg |=> !cycle_end_reg [*3] ##1 cycle_end_reg;
    endproperty
    a_cycle_end: assert property (p_cycle_end) else $error("cycle boundary not every four periods");

    // A word offered during an owed second cycle leaves the decoded fields alone.
    property p_refuse;
        @(posedge clk) disable iff (!rstn)
        (last_w && busy_reg) |=> $stable(fmt_reg) && $stable(literal_reg) && $stable(opcode_reg);
    endproperty
    a_refuse: assert property (p_refuse) else $error("word taken during second cycle");
endmodule
`default_nettype wire

/* File: design/ifd_pkg.sv */
// Constants shared by the instruction format decoder and its phase counter.
// Assumes a single clock domain with a synchronous active-low reset.
`default_nettype none
package ifd_pkg;
    // Word and field widths.
    localparam int WORD_W   = 12;
    localparam int FILE_W   = 5;
    localparam int BIT_W    = 3;
    localparam int LIT_W    = 8;
    localparam int JMP_W    = 9;
    localparam int OPB_W    = 6;
    localparam int OPN_W    = 4;
    localparam int OPJ_W    = 3;
    // Field positions.
    localparam int DEST_POS = 5;
    localparam int BIT_LSB  = 5;
    localparam int OPB_LSB  = 6;
    localparam int OPN_LSB  = 8;
    localparam int OPJ_LSB  = 9;
    // Oscillator periods per instruction cycle.
    localparam int PHASES   = 4;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    // Opcode top nibbles of the instruction groups; the jump opcode is its top three bits.
    localparam logic [3:0] GRP_MISC  = 4'h0;
    localparam logic [3:0] GRP_BITLO  = 4'h4;
    localparam logic [3:0] GRP_BITHI  = 4'h7;
    localparam logic [3:0] GRP_RETURN = 4'h8;
    localparam logic [3:0] GRP_CALL  = 4'h9;
    localparam logic [2:0] OPJ_JUMP  = 3'h5;
    localparam logic [3:0] GRP_LITLO = 4'hC;
    // Byte opcodes that are conditional skips, and the lowest bit-group nibble that skips.
    localparam logic [5:0] OPB_DECSKIP = 6'h0B;
    localparam logic [5:0] OPB_INCSKIP = 6'h0F;
    localparam logic [3:0] OPN_BITSKIP = 4'h6;
    // Decoded instruction formats.
    typedef enum logic [1:0] {
        IFD_FMT_BYTE,
        IFD_FMT_BIT,
        IFD_FMT_LIT,
        IFD_FMT_JUMP
    } ifd_fmt_t;
endpackage
`default_nettype wire

/* File: design/ifd_phase.sv */
// Phase counter that splits each instruction cycle into oscillator periods.
// Assumes clk is the core oscillator and rstn a synchronous active-low reset.
`default_nettype none
module ifd_phase (
    input  wire logic       clk,        // Core oscillator.
    input  wire logic       rstn,       // Synchronous reset, active low.
    output var  logic [1:0] phase_reg,  // Current period within the cycle.
    output var  logic       last_reg    // High in the final period.
);
    import ifd_pkg::*;

    // Count four periods and wrap; the last flag marks the cycle boundary.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            phase_reg <= 2'h0;
            last_reg  <= 1'b0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
            last_reg  <= (phase_reg == PHASE_LAST - 2'h1);
        end
    end

    // The final period recurs every four clocks.
    property p_phase_wrap;
        @(posedge clk) disable iff (!rstn)
        last_reg |=> !last_reg [*3] ##1 last_reg;
    endproperty
    a_phase_wrap: assert property (p_phase_wrap) else $error("phase period not four");
endmodule
`default_nettype wire

/* File: sim/ifd_fetch_model.sv */
// Program memory fetch and datapath test model that offers words to the decoder.
// Assumes the bench requests words on clk; a released bus shows changing data.
`default_nettype none
module ifd_fetch_model (
    input  wire logic        clk,         // Core oscillator.
    input  wire logic        req,         // Bench asks for a word to be offered.
    input  wire logic [11:0] req_word,    // Word to offer.
    input  wire logic        req_skip,    // Test result that goes with the word.
    output var  logic        instr_valid, // Word present.
    output var  logic [11:0] instr_word,  // Offered word.
    output var  logic        skip_true    // Datapath test result.
);
    timeunit 1ns;
    timeprecision 1ps;
    // Starts idle so the decoder never sees an unknown word.
    initial begin
        instr_valid = 1'b0;
        instr_word  = 12'h0000;
        skip_true   = 1'b0;
    end
    // Offers one whole word a clock, and inverts the idle bus so stale data never looks valid.
    always @(posedge clk) begin
        instr_valid <= req;
        instr_word  <= req ? req_word : ~instr_word;
        skip_true   <= req ? req_skip : ~skip_true;
    end
endmodule
`default_nettype wire

/* File: sim/instruction_format_decoder_tb_top.sv */
// Self-checking bench for the instruction format decoder.
// Assumes the fetch model sits in front of the decoder and a 200 MHz clock.
`default_nettype none
module instruction_format_decoder_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ifd_pkg::*;
    logic clk = 0, rstn = 0, req = 0, req_skip = 0, instr_valid, instr_word_skip;
    logic [11:0] req_word = 0, instr_word;
    ifd_fmt_t fmt_reg;
    logic [5:0] opcode_reg;
    logic dest_acc_reg, dest_file_reg, two_cycle_reg, is_cond_reg, cycle_end_reg;
    logic [4:0] file_addr_reg;
    logic [2:0] bit_num_reg;
    logic [7:0] bit_mask_reg, literal_reg;
    logic [8:0] jump_target_reg;
    logic [1:0] phase_out_reg;
    int fail_count = 0, checks = 0, n;
    ifd_fetch_model fetch (.clk(clk), .req(req), .req_word(req_word), .req_skip(req_skip),
        .instr_valid(instr_valid), .instr_word(instr_word), .skip_true(instr_word_skip));
    ifd_decoder dut (.clk(clk), .rstn(rstn), .instr_valid(instr_valid), .instr_word(instr_word),
        .skip_true(instr_word_skip), .fmt_reg(fmt_reg), .opcode_reg(opcode_reg),
        .dest_acc_reg(dest_acc_reg), .dest_file_reg(dest_file_reg), .file_addr_reg(file_addr_reg),
        .bit_num_reg(bit_num_reg), .bit_mask_reg(bit_mask_reg), .literal_reg(literal_reg),
        .jump_target_reg(jump_target_reg), .two_cycle_reg(two_cycle_reg), .is_cond_reg(is_cond_reg),
        .phase_out_reg(phase_out_reg), .cycle_end_reg(cycle_end_reg));
    // Clock of 5 ns period.
    initial begin
        forever #2.5 clk = ~clk;
    end
    // Compares a field value.
    task automatic check_vec(string what, logic [11:0] exp, logic [11:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // Waits for the end of an instruction cycle and returns the clocks it took.
    task automatic wait_end(output int cnt);
        cnt = 0;
        do begin
            @(posedge clk);
            #1;
            cnt++;
        end while (cycle_end_reg !== 1'b1 && cnt < 20);
        check_vec("cycle_end_reg", 12'h001, {11'h0, cycle_end_reg});
    endtask
    // Offers one word, optionally lined up with the next cycle, and holds it until a boundary has passed.
    task automatic offer(logic [11:0] w, logic s, bit sync);
        if (sync) wait_end(n);
        @(posedge clk);
        req      <= 1'b1;
        req_word <= w;
        req_skip <= s;
        wait_end(n);
        @(posedge clk);
        req <= 1'b0;
        #1;
    endtask
    // Ends the run with the counts and the verdict.
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic t_reset();
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        #1;
        check_vec("fmt_reg", 12'(IFD_FMT_LIT), 12'(fmt_reg));
        check_vec("two_cycle_reg", 12'h000, {11'h0, two_cycle_reg});
        wait_end(n);
        wait_end(n);
        check_vec("cycle length", 12'h004, 12'(n));
        check_vec("phase_out_reg", 12'h003, {10'h0, phase_out_reg});
        $display("test reset done");
    endtask
    task automatic t_byte();
        for (int i = 0; i < 2; i++) begin
            offer(i ? 12'h01E0 : 12'h01DF, 1'b0, 1'b1);
            check_vec("fmt_reg", 12'(IFD_FMT_BYTE), 12'(fmt_reg));
            check_vec("opcode_reg", 12'h0007, {6'h0, opcode_reg});
            check_vec("dest_acc_reg", 12'(i == 0), {11'h0, dest_acc_reg});
            check_vec("dest_file_reg", 12'(i == 1), {11'h0, dest_file_reg});
            check_vec("file_addr_reg", i ? 12'h0000 : 12'h001F, {7'h0, file_addr_reg});
        end
        $display("test byte done");
    endtask
    task automatic t_bit();
        for (int b = 0; b < 8; b++) begin
            offer(12'h0500 | 12'(b << 5) | 12'(5'h1F ^ b), 1'b0, 1'b1);
            check_vec("fmt_reg", 12'(IFD_FMT_BIT), 12'(fmt_reg));
            check_vec("opcode_reg", 12'h0014, {6'h0, opcode_reg});
            check_vec("bit_num_reg", 12'(b), {9'h0, bit_num_reg});
            check_vec("bit_mask_reg", 12'(1 << b), {4'h0, bit_mask_reg});
            check_vec("opcode pad", 12'h000, {10'h0, opcode_reg[1:0]});
            check_vec("file_addr_reg", 12'(5'h1F ^ b), {7'h0, file_addr_reg});
        end
        $display("test bit done");
    endtask
    task automatic t_jump();
        offer(12'h0BA5, 1'b0, 1'b1);
        check_vec("fmt_reg", 12'(IFD_FMT_JUMP), 12'(fmt_reg));
        check_vec("opcode_reg", 12'h0028, {6'h0, opcode_reg});
        check_vec("jump_target_reg", 12'h01A5, {3'h0, jump_target_reg});
        check_vec("two_cycle_reg", 12'h001, {11'h0, two_cycle_reg});
        offer(12'h0C33, 1'b0, 1'b0);
        check_vec("fmt_reg", 12'(IFD_FMT_JUMP), 12'(fmt_reg));
        offer(12'h0C33, 1'b0, 1'b1);
        check_vec("fmt_reg", 12'(IFD_FMT_LIT), 12'(fmt_reg));
        check_vec("opcode_reg", 12'h0030, {6'h0, opcode_reg});
        check_vec("literal_reg", 12'h0033, {4'h0, literal_reg});
        check_vec("two_cycle_reg", 12'h000, {11'h0, two_cycle_reg});
        $display("test jump done");
    endtask
    task automatic t_skip();
        logic [11:0] words [4] = '{12'h07E3, 12'h07E3, 12'h02E0, 12'h0955};
        logic [3:0] skips = 4'b0101;
        logic [3:0] twos  = 4'b1101;
        logic [3:0] conds = 4'b0111;
        for (int i = 0; i < 4; i++) begin
            offer(words[i], skips[i], 1'b1);
            check_vec("two_cycle_reg", 12'(twos[i]), {11'h0, two_cycle_reg});
            check_vec("is_cond_reg", 12'(conds[i]), {11'h0, is_cond_reg});
        end
        $display("test skip done");
    endtask
    // Main sequence.
    initial begin
        t_reset();
        t_byte();
        t_bit();
        t_jump();
        t_skip();
        close_out();
    end
    // Watchdog that cuts a hang short.
    initial begin
        #20000;
        fail_count++;
        $display("unexpected watchdog: expected done seen running");
        close_out();
    end
endmodule
`default_nettype wire
